// ===== rtl/pbsc_top.sv
// Purpose: Cycle decode, burst sequencing, power-down and read pipeline
//          of a synchronous pipelined burst memory.
// Assumes: Array outside is read combinationally from arrayAddr and
//          writes the lanes flagged in arrayLaneWr during the cycle.
// Notes:   Reset clears control state and the data registers; memory contents are outside.
`timescale 1ns/1ps
module pbsc_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Address and selects
    input  wire logic [18:0] addrIn,
    input  wire logic        firstSelect_n,
    input  wire logic        secondSelect,
    input  wire logic        thirdSelect_n,
    // Burst control
    input  wire logic        addrStrobeProc_n,
    input  wire logic        addrStrobeCtrl_n,
    input  wire logic        burstStep_n,
    input  wire logic        linearOrder_n,
    // Write control
    input  wire logic        globalWrite_n,
    input  wire logic        byteWriteGate_n,
    input  wire logic [3:0]  laneWrite_n,
    input  wire logic        wideOrg,
    // Asynchronous controls
    input  wire logic        sleepRequest,
    input  wire logic        outputEnable_n,
    // Data lanes
    input  wire logic [35:0] dataByteLaneIn,
    output logic      [35:0] dataByteLaneOut,
    output logic             dataByteLaneOe_n,
    // Array side
    output logic      [18:0] arrayAddr,
    output logic             arrayRead,
    output logic      [3:0]  arrayLaneWr,
    output logic      [35:0] arrayWrData,
    input  wire logic [35:0] arrayRdData,
    // Status
    output logic             powerDown,
    output logic             ready
);
    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    pbsc_ctl_if ctl ();

    pbsc_burst_ctr u_ctr (
        .clk   (clk),
        .rst_b (rst_b),
        .bus   (ctl.counterSide)
    );

    pbsc_lane_dec u_dec (
        .bus (ctl.decodeSide)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    pbsc_pkg::pbsc_pwr_t   pwr_r;
    pbsc_pkg::pbsc_burst_t burst_r;
    logic [1:0]            pwrCnt_r;
    logic [16:0]           base_r;
    logic                  arrayRead_r;
    logic [3:0]            arrayLaneWr_r;
    logic [35:0]           writeData_r;
    logic [35:0]           outReg_r;
    logic                  outRegValid_r;
    logic [35:0]           outBuf_r;
    logic                  outBufValid_r;

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    logic procLow;
    logic allSel;
    logic opOk;
    logic deselHit;
    logic startProc;
    logic startCtrl;
    logic startAny;
    logic stepHit;
    logic advance;
    logic hold;
    logic accRead;
    logic accWrite;

    // A processor strobe is blocked while the first select is high.
    assign procLow   = !addrStrobeProc_n && !firstSelect_n;
    assign allSel    = !firstSelect_n && secondSelect && !thirdSelect_n;
    assign opOk      = (pwr_r == pbsc_pkg::PWR_ON) && !sleepRequest;
    assign deselHit  = opOk && (procLow || !addrStrobeCtrl_n)
                       && !allSel;
    assign startProc = opOk && procLow && allSel;
    assign startCtrl = opOk && !procLow && !addrStrobeCtrl_n
                       && allSel;
    assign startAny  = startProc || startCtrl;
    // Steps only act on a burst that a start has defined.
    assign stepHit   = opOk && addrStrobeCtrl_n && !procLow
                       && (burst_r == pbsc_pkg::BURST_LIVE);
    assign advance   = stepHit && !burstStep_n;
    assign hold      = stepHit && burstStep_n;
    // Lane inputs count on controller starts and steps, never on
    // processor starts, which always read.
    assign accWrite  = (startCtrl || stepHit)
                       && !ctl.combinedWrite_n;
    assign accRead   = startProc
                       || ((startCtrl || stepHit)
                           && ctl.combinedWrite_n);

    assign ctl.load            = startAny;
    assign ctl.step            = advance;
    assign ctl.seed            = addrIn[1:0];
    assign ctl.linearOrder_n   = linearOrder_n;
    assign ctl.globalWrite_n   = globalWrite_n;
    assign ctl.byteWriteGate_n = byteWriteGate_n;
    assign ctl.laneWrite_n     = laneWrite_n;
    assign ctl.wideOrg         = wideOrg;

    // ------------------------------------------------------------------
    // Power-down sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_r    <= pbsc_pkg::PWR_ON;
            pwrCnt_r <= pbsc_pkg::CNT_RST;
        end else begin
            case (pwr_r)
                pbsc_pkg::PWR_ON: begin
                    if (sleepRequest) begin
                        pwr_r    <= pbsc_pkg::PWR_ENTER;
                        pwrCnt_r <= pbsc_pkg::ENTRY_LOAD;
                    end
                end
                pbsc_pkg::PWR_ENTER: begin
                    if (pwrCnt_r == pbsc_pkg::CNT_RST) begin
                        pwr_r <= pbsc_pkg::PWR_DOWN;
                    end else begin
                        pwrCnt_r <= pwrCnt_r - 2'h1;
                    end
                end
                pbsc_pkg::PWR_DOWN: begin
                    if (!sleepRequest) begin
                        pwr_r    <= pbsc_pkg::PWR_WAKE;
                        pwrCnt_r <= pbsc_pkg::WAKE_LOAD;
                    end
                end
                pbsc_pkg::PWR_WAKE: begin
                    if (sleepRequest) begin
                        pwr_r    <= pbsc_pkg::PWR_ENTER;
                        pwrCnt_r <= pbsc_pkg::ENTRY_LOAD;
                    end else if (pwrCnt_r == pbsc_pkg::CNT_RST) begin
                        pwr_r <= pbsc_pkg::PWR_ON;
                    end else begin
                        pwrCnt_r <= pwrCnt_r - 2'h1;
                    end
                end
                default: begin
                    pwr_r <= pbsc_pkg::PWR_ON;
                end
            endcase
        end
    end

    assign powerDown = (pwr_r == pbsc_pkg::PWR_DOWN);
    assign ready     = opOk;

    // ------------------------------------------------------------------
    // Burst state and base address
    // ------------------------------------------------------------------
    // Burst state is kept through sleep, so a burst resumes after wake.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            burst_r <= pbsc_pkg::BURST_IDLE;
        end else if (startAny) begin
            burst_r <= pbsc_pkg::BURST_LIVE;
        end else if (deselHit) begin
            burst_r <= pbsc_pkg::BURST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_r <= pbsc_pkg::ADDR_RST[18:pbsc_pkg::BASE_LSB];
        end else if (startAny) begin
            base_r <= addrIn[18:pbsc_pkg::BASE_LSB];
        end
    end

    assign arrayAddr = {base_r, ctl.count};

    // ------------------------------------------------------------------
    // Array access
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arrayRead_r   <= 1'b0;
            arrayLaneWr_r <= pbsc_pkg::LANES_NONE;
        end else begin
            arrayRead_r   <= accRead;
            arrayLaneWr_r <= accWrite ? ctl.laneWr
                                      : pbsc_pkg::LANES_NONE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            writeData_r <= pbsc_pkg::DATA_RST;
        end else if (accWrite) begin
            writeData_r <= dataByteLaneIn;
        end
    end

    assign arrayRead   = arrayRead_r;
    assign arrayLaneWr = arrayLaneWr_r;
    assign arrayWrData = writeData_r;

    // ------------------------------------------------------------------
    // Read pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outReg_r      <= pbsc_pkg::DATA_RST;
            outRegValid_r <= 1'b0;
        end else begin
            outRegValid_r <= arrayRead_r;
            if (arrayRead_r) begin
                outReg_r <= arrayRdData;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outBuf_r      <= pbsc_pkg::DATA_RST;
            outBufValid_r <= 1'b0;
        end else begin
            outBufValid_r <= outRegValid_r;
            if (outRegValid_r) begin
                outBuf_r <= outReg_r;
            end
        end
    end

    // Output drive is gated without the clock; a write in progress
    // forces the pins off to avoid contention with incoming data.
    assign dataByteLaneOut  = outBuf_r;
    assign dataByteLaneOe_n = !(outBufValid_r && !outputEnable_n
                                && !sleepRequest
                                && (arrayLaneWr_r == pbsc_pkg::LANES_NONE));

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    deselect_quiet_a: assert property (deselHit |=> !arrayRead_r
        && arrayLaneWr_r == pbsc_pkg::LANES_NONE)
        else $error("deselected cycle accessed the array");
    proc_start_a: assert property (startProc |=> arrayRead_r
        && arrayAddr == $past(addrIn))
        else $error("processor start did not read at new address");
    ctrl_write_a: assert property ((startCtrl && !ctl.combinedWrite_n)
        |=> !arrayRead_r && arrayLaneWr_r == $past(ctl.laneWr)
        && arrayAddr == $past(addrIn))
        else $error("controller write start wrong");
    ctrl_read_a: assert property ((startCtrl && ctl.combinedWrite_n)
        |=> arrayRead_r && arrayAddr == $past(addrIn))
        else $error("controller read start wrong");
    burst_advance_a: assert property (advance |=>
        arrayAddr[18:2] == $past(arrayAddr[18:2])
        && arrayAddr[1:0] != $past(arrayAddr[1:0])
        && (arrayRead_r || arrayLaneWr_r != pbsc_pkg::LANES_NONE))
        else $error("burst did not advance");
    burst_hold_a: assert property (hold |=> $stable(arrayAddr)
        && (arrayRead_r != $past(accWrite)))
        else $error("suspended burst moved its address");
    write_flag_a: assert property (ctl.combinedWrite_n
        == (globalWrite_n && (byteWriteGate_n
            || &(laneWrite_n | {!wideOrg, !wideOrg, 2'b00}))))
        else $error("combined write disagrees with lanes");
    global_write_a: assert property ((!globalWrite_n && wideOrg)
        |-> ctl.laneWr == pbsc_pkg::LANES_ALL)
        else $error("global write missed a lane");
    gate_read_a: assert property ((globalWrite_n && byteWriteGate_n)
        |-> ctl.combinedWrite_n)
        else $error("closed gate still wrote");
    lane_select_a: assert property ((globalWrite_n && !byteWriteGate_n
        && wideOrg) |-> ctl.laneWr == ~laneWrite_n)
        else $error("four-lane decode wrong");
    two_lane_a: assert property ((globalWrite_n && !byteWriteGate_n
        && !wideOrg) |-> ctl.laneWr == (~laneWrite_n & pbsc_pkg::LANES_TWO))
        else $error("two-lane decode wrong");
    sleep_block_a: assert property (sleepRequest |-> (!startAny
        && !stepHit && dataByteLaneOe_n)
        ##1 (!arrayRead_r && arrayLaneWr_r == pbsc_pkg::LANES_NONE))
        else $error("operation ran during sleep");
    sleep_entry_a: assert property ((pwr_r == pbsc_pkg::PWR_ON
        && sleepRequest) |-> ##2 powerDown)
        else $error("power-down not reached in two cycles");
    wake_time_a: assert property ((powerDown && !sleepRequest)
        |=> !ready ##1 ($past(sleepRequest) || pwr_r == pbsc_pkg::PWR_ON))
        else $error("wake-up time wrong");
    proc_lanes_a: assert property (startProc
        |=> arrayLaneWr_r == pbsc_pkg::LANES_NONE)
        else $error("lanes honoured on processor start");
    read_pipe_a: assert property (arrayRead_r
        |-> ##2 dataByteLaneOut == $past(arrayRdData, 2))
        else $error("read pipeline depth wrong");
    idle_step_a: assert property ((burst_r == pbsc_pkg::BURST_IDLE
        && !startAny) |=> !arrayRead_r
        && arrayLaneWr_r == pbsc_pkg::LANES_NONE)
        else $error("step acted before any start");

    read_burst_c: cover property (startProc ##1 advance [*3]);
    write_burst_c: cover property ((startCtrl && !ctl.combinedWrite_n)
        ##1 (advance && !ctl.combinedWrite_n));
    sleep_cycle_c: cover property (powerDown ##1 !sleepRequest [*3]
        ##1 ready);
endmodule

// ===== inc/pbsc_pkg.sv
// Purpose: Constants and types of the pipelined burst memory control.
// Assumes: One clock; all control pins synchronous to it except sleep
//          and output enable.
// Notes:   Lanes are nine bits wide; the two-lane organisation uses
//          lanes 0 and 1 only.
//
// Summary of operation
// - A strobe with selects not all active deselects; nothing is accessed. A processor strobe with the first select high is ignored instead.
// - Selected processor strobe low loads address and starts a read burst.
// - Selected controller strobe, processor high, write low: write burst.
// - Selected controller strobe, processor high, write high: read burst.
// - No start strobe, burst step low: advance address, read or write.
// - No start strobe, burst step high: hold address, repeat read or write.
// - Combined write is low exactly when the lane decode yields a write.
// - Global write low writes every lane of the organisation (lanes 0 and 1 only with two lanes), ignoring gate and lane inputs.
// - Four lanes: gate low writes exactly the lanes whose inputs are low.
// - Two lanes: gate low writes only those of lanes 0 and 1 whose inputs are low.
// - Sleep gates the result of every decode; output enable gates only the output drive.
// - Power-down is reached within two cycles after sleep rises.
// - Low address bits seed the counter; linear or interleaved stepping.
// - The burst counter wraps to its starting value after four accesses.
// - Lane inputs ignored on processor starts, sampled on controller starts.
// - Read data passes an output register then an output buffer.
package pbsc_pkg;
    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int CNT_W  = 2;
    localparam int BASE_LSB = 2;
    localparam int LANES  = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = 36;
    // ------------------------------------------------------------------
    // Timing in cycles
    // ------------------------------------------------------------------
    localparam int SLEEP_ENTRY_CYC = 2;
    localparam int WAKE_CYC        = 2;
    localparam logic [1:0] ENTRY_LOAD = 2'(SLEEP_ENTRY_CYC - 2);
    localparam logic [1:0] WAKE_LOAD  = 2'(WAKE_CYC - 2);
    // ------------------------------------------------------------------
    // Reset values and lane sets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;
    localparam logic [LANES-1:0]  LANES_NONE = 4'h0;
    localparam logic [LANES-1:0]  LANES_TWO  = 4'h3;
    localparam logic [LANES-1:0]  LANES_ALL  = 4'hF;
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_ON    = 2'b00,
        PWR_ENTER = 2'b01,
        PWR_DOWN  = 2'b10,
        PWR_WAKE  = 2'b11
    } pbsc_pwr_t;
    typedef enum logic {
        BURST_IDLE = 1'b0,
        BURST_LIVE = 1'b1
    } pbsc_burst_t;
endpackage

// ===== inc/pbsc_ctl_if.sv
// Purpose: Carrier between the control core, counter and lane decoder.
// Assumes: Driven from the control core, the counter and the lane decoder.
// Notes:   Counter output is combinational from its own registers.
`timescale 1ns/1ps
interface pbsc_ctl_if;
    logic       load;
    logic       step;
    logic [1:0] seed;
    logic       linearOrder_n;
    logic [1:0] count;
    logic       globalWrite_n;
    logic       byteWriteGate_n;
    logic [3:0] laneWrite_n;
    logic       wideOrg;
    logic [3:0] laneWr;
    logic       combinedWrite_n;
    modport ctrlSide (output load, step, seed, linearOrder_n,
                      globalWrite_n, byteWriteGate_n, laneWrite_n,
                      wideOrg, input count, laneWr, combinedWrite_n);
    modport counterSide (input load, step, seed, linearOrder_n,
                         output count);
    modport decodeSide (input globalWrite_n, byteWriteGate_n,
                        laneWrite_n, wideOrg,
                        output laneWr, combinedWrite_n);
endinterface

// ===== rtl/pbsc_burst_ctr.sv
// Purpose: Two-bit burst address counter.
// Assumes: Load wins over step in the same cycle.
// Notes:   Order pin is static; changing it mid-burst changes the sequence.
`timescale 1ns/1ps
module pbsc_burst_ctr (
    // Clock and reset
    input wire logic          clk,
    input wire logic          rst_b,
    // Control core
    pbsc_ctl_if.counterSide   bus
);
    logic [1:0] start_r;
    logic [1:0] offset_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_r <= pbsc_pkg::CNT_RST;
        end else if (bus.load) begin
            start_r <= bus.seed;
        end
    end

    // Offset runs modulo four, so the fourth step returns to the seed.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            offset_r <= pbsc_pkg::CNT_RST;
        end else if (bus.load) begin
            offset_r <= pbsc_pkg::CNT_RST;
        end else if (bus.step) begin
            offset_r <= offset_r + 2'h1;
        end
    end

    always_comb begin
        if (bus.linearOrder_n) begin
            bus.count = start_r ^ offset_r;
        end else begin
            bus.count = start_r + offset_r;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    seed_load_a: assert property (bus.load |=> bus.count == $past(bus.seed))
        else $error("burst counter did not load the seed");
    linear_step_a: assert property (
        (bus.step && !bus.load && !bus.linearOrder_n) ##1 !bus.linearOrder_n
        |-> bus.count == $past(bus.count) + 2'h1)
        else $error("linear burst step wrong");
    burst_wrap_a: assert property (
        (bus.load && !bus.step) ##1 (bus.step && !bus.load) [*4]
        |=> bus.count == $past(bus.seed, 5))
        else $error("burst counter did not wrap");
endmodule

// ===== rtl/pbsc_lane_dec.sv
// Purpose: Byte-lane write decode for four-lane and two-lane use.
// Assumes: Inputs are the values sampled on the current edge.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module pbsc_lane_dec (
    // Control core
    pbsc_ctl_if.decodeSide bus
);
    logic [3:0] orgLanes;

    always_comb begin
        orgLanes = bus.wideOrg ? pbsc_pkg::LANES_ALL : pbsc_pkg::LANES_TWO;
        if (!bus.globalWrite_n) begin
            bus.laneWr = orgLanes;
        end else if (bus.byteWriteGate_n) begin
            bus.laneWr = pbsc_pkg::LANES_NONE;
        end else begin
            // Unused upper lanes stay masked in the narrow organisation.
            bus.laneWr = ~bus.laneWrite_n & orgLanes;
        end
        bus.combinedWrite_n = ~|bus.laneWr;
    end
endmodule

// ===== verification/pbsc_array_model.sv
// Purpose: Behavioural memory array behind the burst controller.
// Assumes: Reads follow the address at once; writes land on the edge.
// Notes:   Only the low eight address bits pick a word, to stay small.
`timescale 1ns/1ps
module pbsc_array_model (
    // Clock
    input  wire logic        clk,
    // Array side
    input  wire logic [18:0] addr,
    input  wire logic [3:0]  laneWr,
    input  wire logic [35:0] wrData,
    output logic      [35:0] rdData
);
    logic [35:0] mem [0:255];
    // Words start as a pattern of their address, so stale data shows.
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {20'hC3A5F, 8'(i), ~8'(i)};
    end
    assign rdData = mem[addr[7:0]];
    always @(posedge clk) begin
        for (int j = 0; j < 4; j++) begin
            if (laneWr[j]) mem[addr[7:0]][9*j +: 9] <= wrData[9*j +: 9];
        end
    end
endmodule

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the pipelined burst memory control.
// Assumes: Inputs change on the falling edge; outputs settle by then.
// Notes:   The bench keeps its own copy of the array contents.
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst_b, selA_n, selB, selC_n, stbP_n, stbC_n, step_n;
    logic        order_n, allWr_n, gate_n, wide, sleep, oe_n, dqOe_n, aRd;
    logic        pDown, rdy, on, live, pv1, pv2;
    logic [3:0]  lane_n, aLane;
    logic [18:0] addr, aAddr, base;
    logic [35:0] din, dq, aWd, aRdData, pd1, pd2;
    logic [35:0] refMem [0:255];
    int          numErrors, nCompared, cnt, rs, k;
    pbsc_top uut (.clk(clk), .rst_b(rst_b), .addrIn(addr),
        .firstSelect_n(selA_n), .secondSelect(selB), .thirdSelect_n(selC_n),
        .addrStrobeProc_n(stbP_n), .addrStrobeCtrl_n(stbC_n),
        .burstStep_n(step_n), .linearOrder_n(order_n),
        .globalWrite_n(allWr_n), .byteWriteGate_n(gate_n),
        .laneWrite_n(lane_n), .wideOrg(wide), .sleepRequest(sleep),
        .outputEnable_n(oe_n), .dataByteLaneIn(din), .dataByteLaneOut(dq),
        .dataByteLaneOe_n(dqOe_n), .arrayAddr(aAddr), .arrayRead(aRd),
        .arrayLaneWr(aLane), .arrayWrData(aWd), .arrayRdData(aRdData),
        .powerDown(pDown), .ready(rdy));
    pbsc_array_model arr (.clk(clk), .addr(aAddr), .laneWr(aLane),
        .wrData(aWd), .rdData(aRdData));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic testDone();
        $display("errors %0d compares %0d", numErrors, nCompared);
        if (numErrors == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One clock of the bench model: predict, let the edge pass, compare.
    task automatic cyc();
        logic       sel, pLow, r;
        logic [3:0] l, m;
        logic [1:0] o;
        logic [7:0] w;
        sel = !selA_n && selB && !selC_n;
        pLow = !stbP_n && !selA_n;
        m = wide ? 4'hF : 4'h3;
        l = !allWr_n ? m : (gate_n ? 4'h0 : ~lane_n & m);
        r = 1'b0;
        if (!on || ((pLow || !stbC_n) && !sel)) begin
            l = 4'h0;
            live = on ? 1'b0 : live;
        end else if (pLow || !stbC_n) begin
            base = addr;
            cnt = 0;
            live = 1'b1;
            l = pLow ? 4'h0 : l;
            r = (l == 4'h0);
        end else if (live) begin
            cnt = cnt + int'(!step_n);
            r = (l == 4'h0);
        end else begin
            l = 4'h0;
        end
        o = order_n ? base[1:0] ^ cnt[1:0] : base[1:0] + cnt[1:0];
        w = {base[7:2], o};
        @(negedge clk);
        check(aRd, r);
        check(aLane, l);
        if (r || l != 4'h0) check(aAddr, {base[18:2], o});
        if (l != 4'h0) check(aWd, din);
        if (pv2) check(dq, pd2);
        for (int j = 0; j < 4; j++) begin
            if (l[j]) refMem[w][9*j +: 9] = din[9*j +: 9];
        end
        {pv2, pd2, pv1, pd1} = {pv1, pd1, r, refMem[w]};
    endtask
    initial begin
        rs = 32'hE5A2;
        rst_b = 1'b0;
        {selB, stbP_n, stbC_n, step_n, allWr_n, gate_n, wide} = 7'h7F;
        {selA_n, selC_n, order_n, sleep, oe_n} = 5'h00;
        {lane_n, addr, din} = {4'hF, 19'h00000, 36'h000000000};
        {on, live, pv1, pv2, cnt, base} = 0;
        {numErrors, nCompared} = 0;
        for (k = 0; k < 256; k++) refMem[k] = {20'hC3A5F, 8'(k), ~8'(k)};
        repeat (3) @(negedge clk);
        {rst_b, on, step_n} = 3'b110;
        cyc();
        for (k = 0; k < 16; k++) begin
            addr = 19'($random(rs));
            din = {4'($random(rs)), 32'($random(rs))};
            lane_n = 4'($random(rs));
            {allWr_n, gate_n, wide} = {k[3:2] != 2'h0, k[1], k[0]};
            stbC_n = 1'b0;
            cyc();
            {stbC_n, step_n} = {1'b1, k[2]};
            cyc();
        end
        for (k = 0; k < 2; k++) begin
            {order_n, addr} = {k[0], 19'($random(rs))};
            {stbP_n, allWr_n, gate_n, lane_n} = 7'h00;
            cyc();
            {stbP_n, allWr_n, gate_n, lane_n, step_n} = {7'h7F, 1'b0};
            repeat (4) cyc();
        end
        check(dqOe_n, 1'b0);
        {oe_n, selB, stbP_n} = 3'b100;
        cyc();
        check(dqOe_n, 1'b1);
        {oe_n, selB, selC_n, stbP_n, stbC_n} = 5'b01110;
        cyc();
        check(dqOe_n, 1'b0);
        {selC_n, stbC_n, step_n} = 3'b010;
        cyc();
        {sleep, on, stbP_n} = 3'b100;
        repeat (2) cyc();
        check(pDown, 1'b1);
        check(rdy, 1'b0);
        {sleep, stbP_n} = 2'b01;
        cyc();
        check(rdy, 1'b0);
        cyc();
        check(rdy, 1'b1);
        {on, stbP_n} = 2'b10;
        cyc();
        stbP_n = 1'b1;
        repeat (2) cyc();
        testDone();
    end
endmodule
